// ==== phy_status_pkg.sv ====
package phy_status_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h01;
    localparam logic [ADDR_W-1:0] DETAIL_ADDR = 5'h11;
    // Status word bit positions
    localparam int BIT_T4 = 15;
    localparam int CW_MSB = 14;
    localparam int CW_LSB = 6;
    localparam int CW_W = CW_MSB - CW_LSB + 1;
    localparam int RSV_MSB = 10;
    localparam int RSV_LSB = 7;
    localparam int BIT_PRE = 6;
    localparam int BIT_ANC = 5;
    localparam int BIT_RF = 4;
    localparam int BIT_ANA = 3;
    localparam int BIT_LINK = 2;
    localparam int BIT_JAB = 1;
    localparam int BIT_EXT = 0;
    // Detail word bit positions
    localparam int DT_LINK = 0;
    localparam int DT_RF = 1;
    localparam int DT_JAB = 2;
    // Override field reset: capabilities set, reserved and preamble clear
    localparam logic [CW_W-1:0] CW_RESET = 9'h1e0;
    localparam int CW_FD10 = 12 - CW_LSB;
    localparam int CW_HD10 = 11 - CW_LSB;
    localparam int CW_PRE = BIT_PRE - CW_LSB;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic an_enable;
        logic an_done;
        logic link_ok;
        logic jabber_en;
        logic jabber_evt;
        logic lcw_valid;
        logic lcw_rf;
    } status_in_t;
endpackage

// ==== latch_flag.sv ====
`timescale 1ns/1ps
`default_nettype none
// One latching status bit; ACTIVE picks latch-high or latch-low
module latch_flag
    import phy_status_pkg::*;
#(
    parameter logic ACTIVE = 1'b1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_live,
    input wire logic i_force,
    input wire logic i_read,
    output logic o_flag
);
    logic flag_q;
    logic flag_d;

    // An event in the read cycle wins, so nothing is lost
    assign flag_d = i_force ? ~ACTIVE :
                    (i_live == ACTIVE) ? ACTIVE :
                    i_read ? i_live : flag_q;

    // Storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= RST_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;
endmodule
`default_nettype wire

// ==== phy_status_register.sv ====
`timescale 1ns/1ps
`default_nettype none
// Status register bank behind the management frame engine
module phy_status_register
    import phy_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire mgmt_req_t i_req,
    input wire logic i_override_en,
    input wire status_in_t i_st,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_preamble_optional,
    output logic o_partner_rf
);
    // Match one register address; used for reads and writes
    function automatic logic hit(input mgmt_req_t r, input logic [ADDR_W-1:0] a);
        hit = (r.addr == a);
    endfunction

    logic [CW_W-1:0] cw_q;
    logic [CW_W-1:0] cw_d;
    logic partner_rf_q;
    logic partner_rf_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic an_q;
    logic rf_q;
    logic link_q;
    logic jab_q;
    logic [DATA_W-1:0] st_word;
    logic [DATA_W-1:0] dt_word;

    wire rd_st = i_req.rd & hit(i_req, STATUS_ADDR);
    wire rd_dt = i_req.rd & hit(i_req, DETAIL_ADDR);
    wire rd_any = rd_st | rd_dt;
    wire wr_st = i_req.wr & hit(i_req, STATUS_ADDR);
    wire wr_cw = wr_st & i_override_en;
    wire an_live = i_st.an_enable & i_st.an_done;
    wire an_off = ~i_st.an_enable;
    wire jab_live = i_st.jabber_en & i_st.jabber_evt;
    wire jab_off = ~i_st.jabber_en;

    // Writes without override are dropped silently, as the frame has no error path
    assign cw_d = wr_cw ? i_req.wdata[CW_MSB:CW_LSB] : cw_q;
    // Partner fault copy only moves on a fresh code word
    assign partner_rf_d = i_st.lcw_valid ? i_st.lcw_rf : partner_rf_q;

    // Capability and override storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cw_q <= CW_RESET;
            partner_rf_q <= 1'b0;
        end else begin
            cw_q <= cw_d;
            partner_rf_q <= partner_rf_d;
        end
    end

    // Negotiation complete; a status read or disabling negotiation releases it, restart does not
    latch_flag #(
        .ACTIVE(1'b1),
        .RST_VAL(1'b0)
    ) u_an_done (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_live(an_live),
        .i_force(an_off),
        .i_read(rd_st),
        .o_flag(an_q)
    );

    // Remote fault latch, shared by both status views
    latch_flag #(
        .ACTIVE(1'b1),
        .RST_VAL(1'b0)
    ) u_rem_fault (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_live(partner_rf_q),
        .i_force(1'b0),
        .i_read(rd_any),
        .o_flag(rf_q)
    );

    // Link status latches low so a brief drop is seen
    latch_flag #(
        .ACTIVE(1'b0),
        .RST_VAL(1'b0)
    ) u_link (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_live(i_st.link_ok),
        .i_force(1'b0),
        .i_read(rd_any),
        .o_flag(link_q)
    );

    // Jabber latch, forced clear while detection is off
    latch_flag #(
        .ACTIVE(1'b1),
        .RST_VAL(1'b0)
    ) u_jabber (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_live(jab_live),
        .i_force(jab_off),
        .i_read(rd_any),
        .o_flag(jab_q)
    );

    // Status word; reserved bits are stored but never shown
    always_comb begin
        st_word = '0;
        st_word[BIT_T4] = 1'b0;
        st_word[CW_MSB:CW_LSB] = cw_q;
        st_word[RSV_MSB:RSV_LSB] = '0;
        st_word[BIT_ANC] = an_q;
        st_word[BIT_RF] = rf_q;
        st_word[BIT_ANA] = 1'b1;
        st_word[BIT_LINK] = link_q;
        st_word[BIT_JAB] = jab_q;
        st_word[BIT_EXT] = 1'b1;
    end

    // Detail word carries the aliased latch bits only
    always_comb begin
        dt_word = '0;
        dt_word[DT_LINK] = link_q;
        dt_word[DT_RF] = rf_q;
        dt_word[DT_JAB] = jab_q;
    end

    // Read data sampled before the latches release
    assign rdata_d = rd_st ? st_word : rd_dt ? dt_word : rdata_q;

    // Read return
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rd_any;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    // Frame engine drops its preamble check when this is set
    assign o_preamble_optional = cw_q[CW_PRE];
    assign o_partner_rf = partner_rf_q;

    // Checks run on the register clock; reset suspends all but the reset checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_status_read;
        rd_st;
    endsequence

    sequence s_two_reads;
        s_status_read ##1 s_status_read;
    endsequence

    sequence s_read_back;
        rvalid_q ##0 $past(rd_st);
    endsequence

    sequence s_detail_back;
        rvalid_q ##0 $past(rd_dt);
    endsequence

    property p_fd10_reset;
        disable iff (1'b0) i_rst |=> cw_q[CW_FD10];
    endproperty
    a_fd10_reset: assert property (p_fd10_reset) else $error("10M full duplex not set by reset");

    property p_hd10_reset;
        disable iff (1'b0) i_rst |=> cw_q[CW_HD10];
    endproperty
    a_hd10_reset: assert property (p_hd10_reset) else $error("10M half duplex not set by reset");

    property p_cw_locked;
        (wr_st && !i_override_en) |=> $stable(cw_q);
    endproperty
    a_cw_locked: assert property (p_cw_locked) else $error("Locked override bits changed");

    property p_rsv_zero;
        s_read_back |-> (o_rdata[RSV_MSB:RSV_LSB] == '0);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bits read non-zero");

    property p_pre_write;
        wr_cw |=> (o_preamble_optional == $past(i_req.wdata[BIT_PRE]));
    endproperty
    a_pre_write: assert property (p_pre_write) else $error("Preamble flag not written");

    property p_pre_out;
        s_read_back |-> (o_rdata[BIT_PRE] == $past(o_preamble_optional));
    endproperty
    a_pre_out: assert property (p_pre_out) else $error("Preamble flag mismatch");

    property p_an_off;
        !i_st.an_enable |=> !an_q;
    endproperty
    a_an_off: assert property (p_an_off) else $error("Complete set while disabled");

    property p_an_set;
        (i_st.an_enable && i_st.an_done) |=> an_q;
    endproperty
    a_an_set: assert property (p_an_set) else $error("Complete not set on finish");

    property p_an_hold;
        (an_q && !rd_st && i_st.an_enable) |=> an_q;
    endproperty
    a_an_hold: assert property (p_an_hold) else $error("Complete dropped without read");

    property p_second_read;
        s_two_reads |=> (o_rdata[BIT_LINK] == $past(i_st.link_ok, 2));
    endproperty
    a_second_read: assert property (p_second_read) else $error("Second read not current");

    property p_rf_set;
        (i_st.lcw_valid && i_st.lcw_rf) |=> ##1 rf_q;
    endproperty
    a_rf_set: assert property (p_rf_set) else $error("Remote fault not set");

    property p_rf_alias;
        (rd_dt && !i_st.lcw_valid) |=> (rf_q == partner_rf_q);
    endproperty
    a_rf_alias: assert property (p_rf_alias) else $error("Detail read did not release fault");

    property p_partner;
        i_st.lcw_valid |=> (o_partner_rf == $past(i_st.lcw_rf));
    endproperty
    a_partner: assert property (p_partner) else $error("Partner fault copy stale");

    property p_ability;
        s_read_back |-> (o_rdata[BIT_ANA] && o_rdata[BIT_EXT] && !o_rdata[BIT_T4]);
    endproperty
    a_ability: assert property (p_ability) else $error("Fixed ability bits wrong");

    property p_link_drop;
        !i_st.link_ok |=> !link_q ##1 (!link_q || $past(rd_any));
    endproperty
    a_link_drop: assert property (p_link_drop) else $error("Link drop not latched");

    property p_link_track;
        (rd_any && i_st.link_ok) |=> link_q;
    endproperty
    a_link_track: assert property (p_link_track) else $error("Link not restored after read");

    property p_jab_off;
        !i_st.jabber_en |=> !jab_q;
    endproperty
    a_jab_off: assert property (p_jab_off) else $error("Jabber flag set while disabled");

    property p_jab_set;
        (i_st.jabber_en && i_st.jabber_evt) |=> jab_q;
    endproperty
    a_jab_set: assert property (p_jab_set) else $error("Jabber not latched");

    property p_jab_clear;
        (rd_dt && !i_st.jabber_evt) |=> !jab_q;
    endproperty
    a_jab_clear: assert property (p_jab_clear) else $error("Detail read did not clear jabber");

    property p_t4_zero;
        rd_st |=> !o_rdata[BIT_T4];
    endproperty
    a_t4_zero: assert property (p_t4_zero) else $error("Four-pair bit set");

    property p_ext_one;
        rd_st |=> o_rdata[BIT_EXT];
    endproperty
    a_ext_one: assert property (p_ext_one) else $error("Extended bit clear");

    property p_hold_high;
        (jab_q && !rd_any && i_st.jabber_en) |=> jab_q;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("Latched bit released early");

    property p_reset_all;
        disable iff (1'b0) i_rst |=> (cw_q == CW_RESET) && !an_q && !rf_q && !jab_q && !link_q;
    endproperty
    a_reset_all: assert property (p_reset_all) else $error("Reset defaults wrong");

    // Read return: a hit read answers one cycle later and nothing else does
    property p_read_answer;
        rd_any |=> o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("Read not answered");

    property p_no_answer;
        !rd_any |=> !o_rvalid;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("Answer without a read");

    // Detail view must show the very same latch bits as the status view
    property p_detail_alias;
        s_detail_back |-> (o_rdata[DT_LINK] == $past(link_q)) && (o_rdata[DT_RF] == $past(rf_q))
            && (o_rdata[DT_JAB] == $past(jab_q));
    endproperty
    a_detail_alias: assert property (p_detail_alias) else $error("Detail view differs from latches");

    // A status read releases the shared fault latch as well
    property p_rf_clear_st;
        (rd_st && !partner_rf_q) |=> !rf_q;
    endproperty
    a_rf_clear_st: assert property (p_rf_clear_st) else $error("Status read did not release fault");
endmodule
`default_nettype wire

// ==== station_mgr_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Station manager: read and write strobes on the register port, each held until the next call
module station_mgr_model
    import phy_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic [DATA_W-1:0] i_rdata,
    input wire logic i_rvalid,
    output var mgmt_req_t o_req
);
    initial o_req = '0;

    // Request stays up until the next call, so back-to-back requests need no gap
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic v, output logic [DATA_W-1:0] q);
        o_req = '{rd: !w, wr: w, addr: a, wdata: d & 16'hf87f}; // Reserved bits at default
        @(posedge i_clk);
        #1;
        v = i_rvalid;
        q = i_rdata;
    endtask

    // Idle cycle with strobes released
    task automatic idle();
        o_req = '0;
        @(posedge i_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== phy_status_register_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the status register bank
module phy_status_register_tb;
    import phy_status_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_override_en = 1'b0;
    status_in_t i_st = '0;
    mgmt_req_t i_req;
    logic [DATA_W-1:0] o_rdata;
    logic o_rvalid;
    logic o_preamble_optional;
    logic o_partner_rf;
    int bad_count = 0;
    int check_count = 0;
    int seed = 32'hdf0a_4090;
    logic run = 1'b0;
    logic [CW_W-1:0] cw_q;
    logic an_q, rf_q, jab_q, lnk_q, pf_q;
    logic v;
    logic [DATA_W-1:0] q, e;

    always #50 i_clk = ~i_clk;

    phy_status_register i_phy_status_register (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .i_override_en(i_override_en), .i_st(i_st), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_preamble_optional(o_preamble_optional), .o_partner_rf(o_partner_rf));
    station_mgr_model i_station_mgr_model (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
        .o_req(i_req));

    // Reference state, stepped on the same edge as the design
    wire rd_hit = i_req.rd && (i_req.addr == STATUS_ADDR || i_req.addr == DETAIL_ADDR);
    always @(posedge i_clk) begin
        if (i_rst) begin
            cw_q <= CW_RESET;
            {an_q, rf_q, jab_q, lnk_q, pf_q} <= '0;
        end else begin
            if (i_req.wr && i_req.addr == STATUS_ADDR && i_override_en) cw_q <= i_req.wdata[CW_MSB:CW_LSB];
            if (i_st.lcw_valid) pf_q <= i_st.lcw_rf;
            rf_q <= pf_q || (rf_q && !rd_hit);
            jab_q <= i_st.jabber_en && (i_st.jabber_evt || (jab_q && !rd_hit));
            an_q <= i_st.an_enable && (i_st.an_done || (an_q && !(i_req.rd && i_req.addr == STATUS_ADDR)));
            lnk_q <= i_st.link_ok && (lnk_q || rd_hit);
        end
    end

    function automatic logic [DATA_W-1:0] stat_word();
        return {1'b0, cw_q[8:5], 4'h0, cw_q[0], an_q, rf_q, 1'b1, lnk_q, jab_q, 1'b1};
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected word is taken before the edge that samples the request
    task automatic rd(input logic [ADDR_W-1:0] a);
        e = (a == STATUS_ADDR) ? stat_word() : {13'h0, jab_q, rf_q, lnk_q};
        i_station_mgr_model.xfer(1'b0, a, '0, v, q);
        check({15'h0, v}, {15'h0, a == STATUS_ADDR || a == DETAIL_ADDR});
        if (v === 1'b1) check(q, e);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        i_station_mgr_model.xfer(1'b1, a, d, v, q);
    endtask

    // Hold inputs for one idle cycle
    task automatic st(input logic [6:0] s);
        i_st = s;
        i_station_mgr_model.idle();
    endtask

    // Level outputs compared mid-cycle, once everything has settled
    always @(negedge i_clk) begin
        if (run) begin
            check({15'h0, o_preamble_optional}, {15'h0, cw_q[0]});
            check({15'h0, o_partner_rf}, {15'h0, pf_q});
        end
    end

    task automatic close_out();
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is near 3040 cycles; the limit leaves ample margin
    initial begin
        #2_000_000;
        bad_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        run = 1'b1;
        rd(STATUS_ADDR);
        check(q, 16'h7809);
        wr(STATUS_ADDR, 16'h0000);
        rd(STATUS_ADDR);
        check(q & 16'h7840, 16'h7800);
        i_override_en = 1'b1;
        wr(STATUS_ADDR, 16'hffff);
        wr(DETAIL_ADDR, 16'h0000);
        rd(STATUS_ADDR);
        check(q & 16'h7fc0, 16'h7840);
        rd(5'h02);
        // Jabber set, shared clear, then forced off by the enable
        st(7'h0c);
        i_st = 7'h08;
        rd(DETAIL_ADDR);
        check(q & 16'h0004, 16'h0004);
        rd(STATUS_ADDR);
        check(q & 16'h0002, 16'h0000);
        st(7'h0c);
        st(7'h00);
        rd(STATUS_ADDR);
        check(q & 16'h0002, 16'h0000);
        // Negotiation done, restart, detail read must not release it
        st(7'h60);
        i_st = 7'h40;
        rd(DETAIL_ADDR);
        rd(STATUS_ADDR);
        check(q & 16'h0020, 16'h0020);
        rd(STATUS_ADDR);
        st(7'h60);
        st(7'h20);
        rd(STATUS_ADDR);
        // Remote fault raised then withdrawn by the partner
        st(7'h03);
        st(7'h00);
        rd(DETAIL_ADDR);
        st(7'h02);
        rd(STATUS_ADDR);
        rd(STATUS_ADDR);
        // Link up, drop, recover
        i_st = 7'h10;
        rd(STATUS_ADDR);
        rd(STATUS_ADDR);
        st(7'h00);
        i_st = 7'h10;
        rd(DETAIL_ADDR);
        rd(STATUS_ADDR);
        // Random traffic with events landing on reads as well
        repeat (3000) begin
            i_st = 7'($random(seed));
            i_st.link_ok = ($random(seed) % 8) != 0;
            i_override_en = 1'($random(seed));
            case (2'($random(seed)))
                2'd0: i_station_mgr_model.idle();
                2'd1: rd(STATUS_ADDR);
                2'd2: rd(($random(seed) % 4 == 0) ? 5'($random(seed)) : DETAIL_ADDR);
                default: wr(STATUS_ADDR, 16'($random(seed)));
            endcase
        end
        // Reset in mid-run brings back every default
        i_rst = 1'b1;
        i_st = '0;
        i_station_mgr_model.idle();
        i_rst = 1'b0;
        rd(STATUS_ADDR);
        check(q, 16'h7809);
        close_out();
    end
endmodule
`default_nettype wire
